// [verilog/isomc_pkg.sv]
// Package with shared constants and carrier types for the isolator monitor controller.
package isomc_pkg;
  // Nominal alive settle delay of the isolator, in microseconds.
  localparam int ALIVE_DELAY_US   = 100;
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int ALIVE_DELAY_CYC  = (ALIVE_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Slack added before the host trusts the alive pins, in cycles.
  localparam int ALIVE_MARGIN_CYC = 16;
  localparam int SLAVES           = 4;

  typedef enum logic [1:0] {
    ISOMC_MODE_SINGLE,
    ISOMC_MODE_DAISY,
    ISOMC_MODE_INDEP
  } isomc_mode_t;

  // Alive pins sampled from the isolator, one for side A and one for side B.
  typedef struct packed {
    logic side_a_alive;
    logic side_b_alive;
  } isomc_status_t;
endpackage

// [verilog/isomc_sync.sv]
// Two-flop synchroniser for the slow alive pins.
`timescale 1ns/1ps
`default_nettype none
module isomc_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q      = stage1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= next_stage1;
      q      <= next_q;
    end
  end
endmodule
`default_nettype wire

// [verilog/isomc_host.sv]
// Host-side controller driving the isolator's chip select and MISO enable pins.
// Functional notes
// (R01) Side A alive needs power, ready
// (R02) Side B alive follows side B power
// (R03) Power loss forces outputs to default
// (R04) Alive rises 100us after power seen
// (R05) Undervoltage forces all outputs default
// (R06) Ready and enable inputs are filtered
// (R07) Low enable turns MISO on
// (R08) Daisy chain: one select for all
// (R09) Independent: enable low when any select
// (R10) Single slave: enable tied low
// (R11) Treat alive pins as slow status
// (R12) Each monitor channel is one-way
// (R13) Side A ready low allows transfers
// (R14) MISO driven if select or enable low
// (R15) Alive delay restarts on power loss
`timescale 1ns/1ps
`default_nettype none
module isomc_host #(
  parameter int SLAVES     = isomc_pkg::SLAVES,
  parameter int SETTLE_CYC = isomc_pkg::ALIVE_MARGIN_CYC
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Configuration
  input  wire isomc_pkg::isomc_mode_t mode,
  // Isolator status pins
  input  wire logic               side_a_alive,
  input  wire logic               side_b_alive,
  // User select requests, one per slave, active high
  input  wire logic [SLAVES-1:0]  select_req,
  // Isolator control pins
  output logic                    chip_select_in_n,
  output logic [SLAVES-1:1]       ext_chip_select_n,
  output logic                    miso_output_enable_n,
  // User status
  output logic                    link_ready,
  output logic                    select_refused
);
  isomc_pkg::isomc_status_t status;
  logic [15:0] settle_cnt;
  logic [15:0] next_settle_cnt;
  logic        next_link_ready;
  logic        next_cs_n;
  logic [SLAVES-1:1] next_ext_n;
  logic        next_oe_n;
  logic        next_refused;
  logic        both_alive;

  // Both alive pins pass the synchroniser before any decision reads them. (R06)
  isomc_sync #(.WIDTH(2)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({side_a_alive, side_b_alive}),
    .q       (status)
  );

  // The alive pins are slow status, so the host only debounces their level. (R11)
  // Side A alive carries power and ready, side B alive carries side B power. (R01) (R02)
  assign both_alive = status.side_a_alive && status.side_b_alive; // (R13)

  always_comb begin
    next_settle_cnt = settle_cnt;
    next_link_ready = link_ready;
    if (!both_alive) begin
      // Any drop of alive restarts the wait, mirroring the device's timer. (R15)
      next_settle_cnt = '0; // (R05)
      next_link_ready = 1'b0; // (R03)
    end else if (settle_cnt < 16'(SETTLE_CYC)) begin
      next_settle_cnt = settle_cnt + 16'h0001;
    end else begin
      next_link_ready = 1'b1; // (R04)
    end
  end

  always_comb begin
    next_cs_n    = 1'b1;
    next_ext_n   = '1;
    next_oe_n    = 1'b1;
    next_refused = 1'b0;
    if (!link_ready) begin
      // Without a ready far side, selects would only clock into a dead bus.
      next_refused = |select_req;
    end else begin
      case (mode)
        isomc_pkg::ISOMC_MODE_SINGLE: begin
          next_cs_n = !select_req[0];
          next_oe_n = 1'b0; // (R10)
        end
        isomc_pkg::ISOMC_MODE_DAISY: begin
          next_cs_n = !(|select_req); // (R08)
          next_oe_n = 1'b1; // (R14)
        end
        isomc_pkg::ISOMC_MODE_INDEP: begin
          next_cs_n  = !select_req[0];
          next_ext_n = ~select_req[SLAVES-1:1];
          next_oe_n  = !(|select_req); // (R09)
        end
        default: begin
          next_refused = |select_req;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_cnt           <= '0;
      link_ready           <= 1'b0;
      chip_select_in_n     <= 1'b1;
      ext_chip_select_n    <= '1;
      miso_output_enable_n <= 1'b1;
      select_refused       <= 1'b0;
    end else begin
      // Control pins are only ever driven toward the isolator, never read back. (R12)
      settle_cnt           <= next_settle_cnt;
      link_ready           <= next_link_ready;
      chip_select_in_n     <= next_cs_n;
      ext_chip_select_n    <= next_ext_n;
      miso_output_enable_n <= next_oe_n; // (R07)
      select_refused       <= next_refused;
    end
  end
endmodule
`default_nettype wire

// [testbench/isomc_iso_model.sv]
// Behavioural isolator: alive monitors with settle delay and ready filter.
`timescale 1ns/1ps
`default_nettype none
module isomc_iso_model #(
  parameter int DLY = 25000
) (
  input  wire logic ref_clk,
  input  wire logic pwr,
  input  wire logic side_a_ready_n,
  output logic      side_a_alive,
  output logic      side_b_alive
);
  int   cnt = 0;
  logic r1  = 1'h1;
  logic rdy = 1'h1;
  // The count restarts at each loss, which also gives a minimum low pulse.
  always @(posedge ref_clk) begin
    cnt <= pwr ? cnt + (cnt < DLY) : 0;
    r1 <= side_a_ready_n;
    if (r1 == side_a_ready_n) rdy <= r1;
  end
  assign side_b_alive = cnt == DLY;
  assign side_a_alive = side_b_alive && !rdy;
endmodule
`default_nettype wire

// [testbench/isomc_host_asserts.sv]
// Checker for the isolator host controller's select and enable pins.
`timescale 1ns/1ps
`default_nettype none
module isomc_host_asserts #(
  parameter int SLAVES = 4
) (
  input wire logic                   ref_clk, rst, side_a_alive, side_b_alive,
  input wire isomc_pkg::isomc_mode_t mode,
  input wire logic [SLAVES-1:0]      select_req,
  input wire logic [SLAVES-1:1]      ext_chip_select_n,
  input wire logic                   chip_select_in_n, miso_output_enable_n, link_ready, select_refused
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_daisy_one_cs: assert property (mode == 1 && link_ready ##1 link_ready |->
    chip_select_in_n == !$past(|select_req) && &ext_chip_select_n && miso_output_enable_n) else $error("daisy");
  a_indep_en_any: assert property (mode == 2 && link_ready ##1 link_ready |->
    miso_output_enable_n == !$past(|select_req) && chip_select_in_n == !$past(select_req[0])
    && ext_chip_select_n == ~$past(select_req[SLAVES-1:1])) else $error("indep");
  a_single_en_low: assert property (mode == 0 && link_ready ##1 link_ready |-> !miso_output_enable_n)
    else $error("single");
  a_wait_ready: assert property (!link_ready ##1 !link_ready |-> select_refused == $past(|select_req)
    && chip_select_in_n && &ext_chip_select_n && miso_output_enable_n) else $error("refuse");
  a_slow_alive: assert property ($rose(link_ready) |-> $past(side_a_alive && side_b_alive, 3))
    else $error("alive");
  c_indep: cover property (mode == 2 && link_ready && select_req[3]);
  c_drop: cover property ($fell(link_ready));
  c_refuse: cover property (select_refused);
endmodule
bind isomc_host isomc_host_asserts #(.SLAVES(SLAVES)) i_chk (.*);
`default_nettype wire

// [testbench/isomc_host_tb.sv]
// Self-checking bench for the isolator host controller.
`timescale 1ns/1ps
`default_nettype none
module isomc_host_tb;
  logic ref_clk = 0, rst = 1, pwr = 0, side_a_ready_n = 1, side_a_alive, side_b_alive;
  logic chip_select_in_n, miso_output_enable_n, link_ready, select_refused;
  logic [3:0] select_req = 0;
  logic [3:1] ext_chip_select_n;
  logic [6:0] got;
  isomc_pkg::isomc_mode_t mode = isomc_pkg::ISOMC_MODE_SINGLE;
  int error_cnt = 0, checked = 0, m;
  assign got = {link_ready, select_refused, chip_select_in_n, ext_chip_select_n, miso_output_enable_n};
  initial forever #2 ref_clk = ~ref_clk;
  isomc_host #(.SETTLE_CYC(2)) i_dut (.*);
  isomc_iso_model #(.DLY(20)) i_iso (.*);
  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [6:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  // The run needs about 1.24 us; the limit leaves ample slack.
  initial begin
    #4000;
    error_cnt++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h082E));
    repeat (5) @(negedge ref_clk);
    rst = 0;
    for (m = 0; m < 3; m++) begin
      mode = isomc_pkg::isomc_mode_t'(m);
      pwr = 1;
      side_a_ready_n = 0;
      repeat (40) @(negedge ref_clk);
      repeat (50) begin
        select_req = 4'($urandom % 16);
        @(negedge ref_clk);
        chk({2'h2, m == 1 ? ~|select_req : ~select_req[0], m == 2 ? ~select_req[3:1] : 3'h7, m == 0 ? 1'h0 : m == 1 ? 1'h1 : ~|select_req});
      end
      side_a_ready_n = 1;
      repeat (8) @(negedge ref_clk);
      chk({1'h0, |select_req, 5'h1F});
      pwr = 0;
      repeat (4) @(negedge ref_clk);
    end
    complete_run;
  end
endmodule
`default_nettype wire
